// ===== verilog/fph_consts.svh
// constants of the flash id, sleep and pause command logic
`ifndef FPH_CONSTS_SVH
`define FPH_CONSTS_SVH

// ****************************************************************
// opcodes
// ****************************************************************
`define FPH_OP_LEGACY_ID 8'h90
`define FPH_OP_SLEEP 8'hB9
`define FPH_OP_WAKE 8'hAB

// ****************************************************************
// identification bytes (arbitrary values)
// ****************************************************************
`define FPH_MANUF_CODE 8'h5A
`define FPH_DEVICE_CODE 8'h3C

// ****************************************************************
// frame layout
// ****************************************************************
`define FPH_DUMMY_BYTES 3'h3
`define FPH_WAKE_ID_BYTE 3'h4
`define FPH_LAST_BIT 3'h7
`define FPH_PIN_IDLE 5'h19

// ****************************************************************
// timing: ns figures and derived 100 MHz cycle counts
// ****************************************************************
`define FPH_CLK_NS 10
`define FPH_ENTRY_NS 3000
`define FPH_EXIT_NS 3000
`define FPH_MAX1(x) (((x) < 1) ? 1 : (x))
`define FPH_ENTRY_CYC `FPH_MAX1(`FPH_ENTRY_NS / `FPH_CLK_NS)
`define FPH_EXIT_CYC `FPH_MAX1(`FPH_EXIT_NS / `FPH_CLK_NS)
`define FPH_TIMER_W 12

`endif

// ===== verilog/fph_pkg.sv
// types of the flash id, sleep and pause command logic
package fph_pkg;

    // gray codes along standby -> entering -> sleep -> exiting
    typedef enum logic [1:0]
    {
        PWR_STANDBY = 2'h0,
        PWR_ENTERING = 2'h1,
        PWR_SLEEP = 2'h3,
        PWR_EXITING = 2'h2
    } fph_pwr_t;

    typedef enum logic [2:0]
    {
        CMD_OPCODE = 3'h0,
        CMD_LEGACY_ID = 3'h1,
        CMD_WAKE = 3'h3,
        CMD_SKIP = 3'h2,
        CMD_FORWARD = 3'h6
    } fph_cmd_t;

endpackage

// ===== verilog/fph_pins_if.sv
// synchronised serial pin levels and edges
`timescale 1ns/100ps
interface fph_pins_if;
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;

    modport src
    (
        output cs_n, sck, si, hold_n, wp_n, cs_rise, sck_rise, sck_fall
    );
    modport dst
    (
        input cs_n, sck, si, hold_n, wp_n, cs_rise, sck_rise, sck_fall
    );
endinterface

// ===== verilog/fph_pin_sync.sv
// two-flop synchronisers and edge detect for the serial pins
`timescale 1ns/100ps
`include "fph_consts.svh"
module fph_pin_sync
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic hold_n_pin,
    input wire logic wp_n_pin,
    fph_pins_if.src pins
);
    // bit order {wp_n, hold_n, si, sck, cs_n}
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic [4:0] last_q;
    wire [4:0] raw = {wp_n_pin, hold_n_pin, si_pin, sck_pin, cs_n_pin};

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta_q <= `FPH_PIN_IDLE;
            sync_q <= `FPH_PIN_IDLE;
            last_q <= `FPH_PIN_IDLE;
        end
        else
        begin
            meta_q <= raw;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // edges look only at the second stage and its delayed copy
    assign pins.cs_n = sync_q[0];
    assign pins.sck = sync_q[1];
    assign pins.si = sync_q[2];
    assign pins.hold_n = sync_q[3];
    assign pins.wp_n = sync_q[4];
    assign pins.cs_rise = sync_q[0] & ~last_q[0];
    assign pins.sck_rise = sync_q[1] & ~last_q[1];
    assign pins.sck_fall = ~sync_q[1] & last_q[1];
endmodule

// ===== verilog/fph_ctrl.sv
// id read, deep sleep, wake-up and serial pause control of a flash
`timescale 1ns/100ps
`include "fph_consts.svh"

module fph_ctrl
    import fph_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n_pin,
    input wire logic sck_pin,
    input wire logic si_pin,
    input wire logic hold_n_in,
    output logic hold_n_out,
    output logic hold_n_oe_n,
    input wire logic wp_n_pin,
    output logic so_out,
    output logic so_oe_n,
    input wire logic quad_enable_bit,
    input wire logic self_timed_busy,
    input wire logic io3_data,
    input wire logic io3_drive,
    output logic io3_level,
    output logic wp_n_level,
    output logic [7:0] fwd_opcode,
    output logic fwd_valid,
    output logic op_abort,
    output logic write_latch_clear,
    output logic standby,
    output logic deep_sleep
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    fph_pins_if pins();

    fph_pin_sync u_sync
    (
        .clk(clk),
        .reset_n(reset_n),
        .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin),
        .si_pin(si_pin),
        .hold_n_pin(hold_n_in),
        .wp_n_pin(wp_n_pin),
        .pins(pins)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic id_bit(input logic [7:0] code,
                                    input logic [2:0] idx);
        // idx 0 is the first bit out, which is bit 7
        id_bit = code[3'h7 - idx];
    endfunction

    localparam logic [`FPH_TIMER_W-1:0] ENTRY_LOAD =
        `FPH_TIMER_W'(`FPH_ENTRY_CYC - 1);
    localparam logic [`FPH_TIMER_W-1:0] EXIT_LOAD =
        `FPH_TIMER_W'(`FPH_EXIT_CYC - 1);

    // ****************************************************************
    // state
    // ****************************************************************
    fph_pwr_t pwr_q;
    fph_pwr_t pwr_d;
    fph_cmd_t cmd_q;
    fph_cmd_t cmd_d;
    logic hold_active_q;
    logic hold_active_d;
    logic [2:0] bit_cnt_q;
    logic [2:0] byte_cnt_q;
    logic [7:0] shift_q;
    logic [3:0] out_cnt_q;
    logic out_on_q;
    logic so_q;
    logic so_d;
    logic sleep_req_q;
    logic wake_req_q;
    logic [`FPH_TIMER_W-1:0] timer_q;
    logic [`FPH_TIMER_W-1:0] timer_d;
    logic [7:0] fwd_opcode_q;
    logic fwd_valid_q;
    logic abort_q;
    logic io3_q;

    // ****************************************************************
    // pause decode
    // ****************************************************************
    // quad mode turns the pause pin into a data line
    wire pause_fn = ~quad_enable_bit;
    wire pause_req = pause_fn & ~pins.hold_n;

    // pause state changes only while the clock is low; deselect clears it
    wire hold_next = ~pins.sck ? pause_req : hold_active_q;
    assign hold_active_d = pins.cs_n ? 1'b0 : hold_next;

    // clock edges seen during pause are dropped
    wire rise_ok = pins.sck_rise & ~pins.cs_n & ~hold_active_q;
    wire fall_ok = pins.sck_fall & ~pins.cs_n & ~hold_active_q;

    // ****************************************************************
    // opcode decode
    // ****************************************************************
    wire [7:0] opc_val = {shift_q[6:0], pins.si};
    wire byte_end = rise_ok & (bit_cnt_q == `FPH_LAST_BIT);
    wire opc_done = byte_end & (cmd_q == CMD_OPCODE);
    wire asleep = (pwr_q != PWR_STANDBY);
    wire in_sleep = (pwr_q == PWR_SLEEP);
    wire is_lid = (opc_val == `FPH_OP_LEGACY_ID) & ~asleep;
    wire is_sleep = (opc_val == `FPH_OP_SLEEP) & ~asleep;
    wire is_wake = (opc_val == `FPH_OP_WAKE) &
                   (in_sleep | ~asleep);
    // self-timed work in flight swallows the sleep request
    wire sleep_ok = is_sleep & ~self_timed_busy;
    wire id_phase = (cmd_q == CMD_WAKE) &
                    (byte_cnt_q == `FPH_WAKE_ID_BYTE);

    // ****************************************************************
    // end of frame
    // ****************************************************************
    wire frame_end = pins.cs_rise;
    wire on_boundary = (bit_cnt_q == 3'h0);
    // released with the pause pin still low: abandon everything
    wire pause_abort = frame_end & pause_fn & ~pins.hold_n;
    wire go_sleep = frame_end & sleep_req_q & on_boundary &
                    ~pause_abort & ~self_timed_busy;
    wire go_wake = frame_end & wake_req_q & on_boundary &
                   ~pause_abort;

    // ****************************************************************
    // command sequencing
    // ****************************************************************
    always_comb
    begin
        cmd_d = cmd_q;
        case (cmd_q)
            CMD_OPCODE:
            begin
                if (opc_done)
                begin
                    if (is_lid)
                        cmd_d = CMD_LEGACY_ID;
                    else if (is_wake)
                        cmd_d = CMD_WAKE;
                    else if (asleep)
                        cmd_d = CMD_SKIP;
                    else if (is_sleep)
                        cmd_d = CMD_SKIP;
                    else
                        cmd_d = CMD_FORWARD;
                end
            end
            CMD_LEGACY_ID: cmd_d = CMD_LEGACY_ID;
            CMD_WAKE: cmd_d = CMD_WAKE;
            CMD_SKIP: cmd_d = CMD_SKIP;
            CMD_FORWARD: cmd_d = CMD_FORWARD;
            default: cmd_d = CMD_OPCODE;
        endcase
        if (pins.cs_n)
            cmd_d = CMD_OPCODE;
    end

    // ****************************************************************
    // serial output
    // ****************************************************************
    always_comb
    begin
        so_d = so_q;
        if (fall_ok & (cmd_q == CMD_LEGACY_ID))
            so_d = id_bit(out_cnt_q[3] ? `FPH_DEVICE_CODE : `FPH_MANUF_CODE,
                          out_cnt_q[2:0]);
        else if (fall_ok & id_phase)
            so_d = id_bit(`FPH_DEVICE_CODE, out_cnt_q[2:0]);
    end

    wire out_step = fall_ok & ((cmd_q == CMD_LEGACY_ID) | id_phase);

    // ****************************************************************
    // power state
    // ****************************************************************
    always_comb
    begin
        pwr_d = pwr_q;
        timer_d = timer_q;
        case (pwr_q)
            PWR_STANDBY:
            begin
                if (go_sleep)
                begin
                    pwr_d = PWR_ENTERING;
                    timer_d = ENTRY_LOAD;
                end
            end
            PWR_ENTERING:
            begin
                if (timer_q == '0)
                    pwr_d = PWR_SLEEP;
                else
                    timer_d = timer_q - 1'b1;
            end
            PWR_SLEEP:
            begin
                if (go_wake)
                begin
                    pwr_d = PWR_EXITING;
                    timer_d = EXIT_LOAD;
                end
            end
            PWR_EXITING:
            begin
                if (timer_q == '0)
                    pwr_d = PWR_STANDBY;
                else
                    timer_d = timer_q - 1'b1;
            end
            default: pwr_d = PWR_STANDBY;
        endcase
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pwr_q <= PWR_STANDBY;
            timer_q <= '0;
            cmd_q <= CMD_OPCODE;
            hold_active_q <= 1'b0;
        end
        else
        begin
            pwr_q <= pwr_d;
            timer_q <= timer_d;
            cmd_q <= cmd_d;
            hold_active_q <= hold_active_d;
        end
    end

    // bit and byte position within the frame
    always_ff @(posedge clk)
    begin
        if (!reset_n || pins.cs_n)
        begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            shift_q <= 8'h00;
        end
        else if (rise_ok)
        begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q <= opc_val;
            if (byte_end && byte_cnt_q != `FPH_WAKE_ID_BYTE)
                byte_cnt_q <= byte_cnt_q + 3'h1;
        end
    end

    // pending power requests of the current frame
    always_ff @(posedge clk)
    begin
        if (!reset_n || (pins.cs_n && !frame_end))
        begin
            sleep_req_q <= 1'b0;
            wake_req_q <= 1'b0;
        end
        else if (opc_done)
        begin
            sleep_req_q <= sleep_ok;
            wake_req_q <= is_wake & in_sleep;
        end
    end

    // id output sequencer; the counter wraps, so bytes repeat
    always_ff @(posedge clk)
    begin
        if (!reset_n || pins.cs_n)
        begin
            out_cnt_q <= 4'h0;
            out_on_q <= 1'b0;
            so_q <= 1'b0;
        end
        else
        begin
            so_q <= so_d;
            if (out_step)
            begin
                out_cnt_q <= out_cnt_q + 4'h1;
                out_on_q <= 1'b1;
            end
        end
    end

    // side effects toward the rest of the device
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            fwd_opcode_q <= 8'h00;
            fwd_valid_q <= 1'b0;
            abort_q <= 1'b0;
            io3_q <= 1'b0;
        end
        else
        begin
            fwd_valid_q <= opc_done & (cmd_d == CMD_FORWARD);
            if (opc_done)
                fwd_opcode_q <= opc_val;
            abort_q <= pause_abort;
            io3_q <= io3_data;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // output only after the first bit was loaded; pause floats it
    wire so_drive = out_on_q & ~pins.cs_n & ~hold_active_q;
    assign so_out = so_q;
    assign so_oe_n = ~so_drive;
    assign hold_n_out = io3_q;
    assign hold_n_oe_n = ~(quad_enable_bit & io3_drive);
    assign io3_level = pins.hold_n;
    // write protect stays visible during pause
    assign wp_n_level = pins.wp_n;
    assign fwd_opcode = fwd_opcode_q;
    assign fwd_valid = fwd_valid_q;
    assign op_abort = abort_q;
    assign write_latch_clear = abort_q;
    // busy work is never held off by pause; it blocks standby and sleep entry
    assign standby = (pwr_q == PWR_STANDBY) & pins.cs_n &
                     ~self_timed_busy;
    assign deep_sleep = in_sleep;

endmodule

// ===== testbench/fph_ctrl_assertions.sv
// port assertions of the flash id, sleep and pause control
`timescale 1ns/100ps
module fph_ctrl_chk
(
    input logic clk,
    input logic reset_n,
    input logic cs_n_pin,
    input logic sck_pin,
    input logic si_pin,
    input logic hold_n_in,
    input logic hold_n_out,
    input logic hold_n_oe_n,
    input logic wp_n_pin,
    input logic so_out,
    input logic so_oe_n,
    input logic quad_enable_bit,
    input logic self_timed_busy,
    input logic io3_data,
    input logic io3_drive,
    input logic io3_level,
    input logic wp_n_level,
    input logic [7:0] fwd_opcode,
    input logic fwd_valid,
    input logic op_abort,
    input logic write_latch_clear,
    input logic standby,
    input logic deep_sleep
);
    // ****
    // relations at the ports
    // ****
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // lengths cover the two-flop pin sync plus one register
    sequence s_deselected;
        cs_n_pin [*4];
    endsequence
    sequence s_selected;
        !cs_n_pin [*4];
    endsequence
    sequence s_paused;
        (!cs_n_pin && !hold_n_in && !sck_pin && !quad_enable_bit) [*6];
    endsequence

    a_float_idle: assert property (s_deselected |-> so_oe_n)
        else $error("serial output driven while deselected");
    a_pause_float: assert property (s_paused |-> so_oe_n)
        else $error("serial output driven while paused");
    a_abort_pulse: assert property (op_abort |-> cs_n_pin ##1 !op_abort)
        else $error("abort pulse without select release");
    a_latch_clear: assert property (op_abort |-> write_latch_clear)
        else $error("write latch not cleared on abort");
    a_sleep_deaf: assert property (deep_sleep |-> !fwd_valid)
        else $error("opcode forwarded in deep sleep");
    a_busy_awake: assert property (self_timed_busy |-> !standby)
        else $error("standby during self-timed operation");
    a_select_active: assert property (s_selected |-> !standby)
        else $error("standby while selected");
    a_entry_quiet: assert property ($rose(deep_sleep) |-> cs_n_pin && $past(cs_n_pin, 8))
        else $error("sleep entered without select release");
    a_exit_wait: assert property ($fell(deep_sleep) |-> !standby [*8])
        else $error("standby before the exit time");
    a_io3_enable: assert property (hold_n_oe_n == !(quad_enable_bit && io3_drive))
        else $error("io3 enable wrong");
    a_wp_live: assert property (wp_n_pin [*4] |-> wp_n_level == wp_n_pin)
        else $error("write protect level stale");
    a_reset_home: assert property (disable iff (1'b0) !reset_n |=> !deep_sleep && so_oe_n)
        else $error("reset did not land in standby");
endmodule

bind fph_ctrl fph_ctrl_chk chk (.*);

// ===== testbench/fph_host_model.sv
// spi host model driving select, clock, data and pause
`timescale 1ns/100ps
module fph_host_model
(
    input wire logic clk,
    input wire logic so_out,
    input wire logic so_oe_n,
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n
);
    // ****
    // bus cycles
    // ****
    // halves of 6 clocks leave room for the two-flop pin sync
    localparam int HALF = 6;

    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
    end

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic open;
        @(posedge clk);
        cs_n <= 1'b0;
        waitc(HALF);
    endtask

    // a released data line shows the inverse, never a stale bit
    task automatic close;
        cs_n <= 1'b1;
        si <= ~si;
        waitc(8);
    endtask

    // output read late in the low half; a floating line reads unknown
    task automatic shift(input logic b, output logic r);
        si <= b;
        waitc(HALF);
        r = so_oe_n ? 1'bx : so_out;
        sck <= 1'b1;
        waitc(HALF);
        sck <= 1'b0;
    endtask

    task automatic send(input logic [31:0] v, input int n);
        logic r;
        for (int i = 0; i < n; i++)
            shift(v[31 - i], r);
    endtask

    task automatic recv(input int n, output logic [15:0] q);
        logic r;
        q = '0;
        repeat (n)
        begin
            shift(1'b0, r);
            q = {q[14:0], r};
        end
    endtask

    // pause pin moves only in the middle of a clock-low phase
    task automatic pause(input logic on);
        waitc(5);
        hold_n <= ~on;
        waitc(5);
    endtask
endmodule

// ===== testbench/flash_id_powerdown_hold_ctrl_bench.sv
// self-checking bench of the flash id, sleep and pause control
`timescale 1ns/100ps
module flash_id_powerdown_hold_ctrl_bench
    import fph_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic quad_enable_bit = 1'b0;
    logic self_timed_busy = 1'b0;
    logic io3_data = 1'b0;
    logic io3_drive = 1'b0;
    logic wp_n_pin = 1'b1;
    logic cs_n_pin, sck_pin, si_pin, hold_host, hold_n_out, hold_n_oe_n;
    logic so_out, so_oe_n, io3_level, wp_n_level, fwd_valid, op_abort;
    logic write_latch_clear, standby, deep_sleep;
    logic [7:0] fwd_opcode;
    logic [15:0] q;
    int failures = 0;
    int cmp_count = 0;
    int fwd_cnt = 0;
    int abort_cnt = 0;
    int base;
    wire hold_n_in = hold_n_oe_n ? hold_host : hold_n_out;

    fph_ctrl dut
    (
        .clk(clk),
        .reset_n(reset_n),
        .cs_n_pin(cs_n_pin),
        .sck_pin(sck_pin),
        .si_pin(si_pin),
        .hold_n_in(hold_n_in),
        .hold_n_out(hold_n_out),
        .hold_n_oe_n(hold_n_oe_n),
        .wp_n_pin(wp_n_pin),
        .so_out(so_out),
        .so_oe_n(so_oe_n),
        .quad_enable_bit(quad_enable_bit),
        .self_timed_busy(self_timed_busy),
        .io3_data(io3_data),
        .io3_drive(io3_drive),
        .io3_level(io3_level),
        .wp_n_level(wp_n_level),
        .fwd_opcode(fwd_opcode),
        .fwd_valid(fwd_valid),
        .op_abort(op_abort),
        .write_latch_clear(write_latch_clear),
        .standby(standby),
        .deep_sleep(deep_sleep)
    );
    fph_host_model host (.clk(clk), .so_out(so_out), .so_oe_n(so_oe_n),
        .cs_n(cs_n_pin), .sck(sck_pin), .si(si_pin), .hold_n(hold_host));

    initial
    begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        fwd_cnt <= fwd_cnt + (fwd_valid === 1'b1);
        abort_cnt <= abort_cnt + (op_abort === 1'b1);
    end

    // ****
    // helpers
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [31:0] v, input int n);
        host.open();
        host.send(v, n);
        host.close();
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_id;
        host.open();
        host.send(32'h9000_0000, 8);
        host.recv(16, q);
        chk(q, 16'h5A3C);
        host.recv(12, q);
        chk(q, 16'h05A3);
        host.close();
        chk(so_oe_n, 1'b1);
    endtask

    task automatic t_busy;
        self_timed_busy <= 1'b1;
        frame(32'hB900_0000, 8);
        chk(standby, 1'b0);
        host.waitc(320);
        chk(deep_sleep, 1'b0);
        self_timed_busy <= 1'b0;
        host.waitc(4);
        chk(standby, 1'b1);
    endtask

    task automatic t_sleep_bad;
        for (int n = 7; n <= 12; n += 5)
        begin
            frame(32'hB9F0_0000, n);
            host.waitc(320);
            chk(deep_sleep, 1'b0);
        end
    endtask

    task automatic t_sleep;
        base = fwd_cnt;
        frame(32'h0300_0000, 8);
        chk(16'(fwd_cnt - base), 16'h0001);
        frame(32'hB9A5_0000, 16);
        host.waitc(310);
        chk(deep_sleep, 1'b1);
        base = fwd_cnt;
        frame(32'h0300_0000, 8);
        chk(16'(fwd_cnt - base), 16'h0000);
        host.open();
        host.send(32'h9000_0000, 8);
        host.recv(16, q);
        host.close();
        chk(q, 16'hxxxx);
    endtask

    task automatic t_wake_bad;
        for (int n = 7; n <= 12; n += 5)
        begin
            frame(32'hABF0_0000, n);
            host.waitc(320);
            chk(deep_sleep, 1'b1);
        end
    endtask

    task automatic t_wake_id;
        host.open();
        host.send(32'hAB00_0000, 32);
        host.recv(16, q);
        chk(q, 16'h3C3C);
        host.close();
        chk(deep_sleep, 1'b0);
        host.waitc(310);
        chk(standby, 1'b1);
    endtask

    task automatic t_pause;
        host.open();
        host.send(32'h9000_0000, 8);
        host.recv(4, q);
        chk(q, 16'h0005);
        host.pause(1'b1);
        wp_n_pin <= 1'b0;
        host.recv(4, q);
        chk(q, 16'h000x);
        chk(wp_n_level, 1'b0);
        wp_n_pin <= 1'b1;
        host.pause(1'b0);
        host.recv(4, q);
        chk(q, 16'h000A);
        host.pause(1'b1);
        base = abort_cnt;
        host.close();
        chk(16'(abort_cnt - base), 16'h0001);
        host.pause(1'b0);
    endtask

    // with quad mode the device drives the pause pin low and no pause follows
    task automatic t_quad;
        quad_enable_bit <= 1'b1;
        io3_drive <= 1'b1;
        host.waitc(4);
        chk(hold_n_oe_n, 1'b0);
        chk(io3_level, 1'b0);
        host.open();
        host.send(32'h9000_0000, 8);
        host.recv(8, q);
        chk(q, 16'h005A);
        host.close();
        io3_data <= 1'b1;
        host.waitc(5);
        chk(hold_n_out, 1'b1);
        chk(io3_level, 1'b1);
        io3_data <= 1'b0;
        host.waitc(5);
        chk(io3_level, 1'b0);
        io3_drive <= 1'b0;
        quad_enable_bit <= 1'b0;
    endtask

    initial
    begin
        host.waitc(5);
        reset_n <= 1'b1;
        host.waitc(4);
        chk(deep_sleep, 1'b0);
        chk(standby, 1'b1);
        t_id();
        t_busy();
        t_sleep_bad();
        t_sleep();
        t_wake_bad();
        t_wake_id();
        t_id();
        t_pause();
        t_quad();
        conclude();
    end

    initial
    begin
        host.waitc(20000);
        failures++;
        conclude();
    end
endmodule
